// file: src/sirq_pkg.sv
package sirq_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_STATUS_FOUR = 12'hD13;
    localparam logic [11:0] IDX_STATUS_FIVE = 12'hD14;
    localparam logic [11:0] IDX_STATUS_SIX = 12'hD15;
    localparam logic [11:0] IDX_MASK_ONE = 12'hD18;
    localparam logic [11:0] IDX_MASK_TWO = 12'hD19;
    localparam logic [11:0] IDX_MASK_THREE = 12'hD1A;
    localparam logic [11:0] IDX_MASK_FOUR = 12'hD1B;
    localparam logic [11:0] IDX_MASK_FIVE = 12'hD1C;
    localparam logic [11:0] IDX_MASK_SIX = 12'hD1D;
    localparam logic [11:0] IDX_OUT_CTRL = 12'hD1F;
    localparam logic [11:0] IDX_AOD_STATUS = 12'hD52;
    localparam logic [11:0] IDX_AOD_MASK = 12'hD54;

    localparam int REG_W = 16;
    localparam int IDX_W = 12;
    localparam int BYTE_SHIFT = 2;

    // Status word four layout
    localparam int S4_HP_DONE_LSB = 0;
    localparam int S4_ISRC_C_ERR = 6;
    localparam int S4_ISRC_B_ERR = 7;
    // Status word five layout
    localparam int S5_LOOP_A_OK = 0;
    localparam int S5_LOOP_B_OK = 1;
    localparam int S5_ASRC_ERR = 3;
    localparam int S5_ADC_FIFO = 4;
    localparam int S5_ADC_OVF = 5;
    localparam int S5_BOOT_DONE = 8;
    // Status word six layout
    localparam int S6_HP_SHORT_LSB = 0;
    localparam int S6_SPK_SHORT_L = 12;
    localparam int S6_SPK_SHORT_R = 13;
    localparam int S6_SPK_SHUTDOWN = 14;
    localparam int S6_SHARED_COLL = 15;
    // Always-on word layout
    localparam int AOD_CLAMP_RISE = 6;
    localparam int AOD_CLAMP_FALL = 7;
    // Output control layout
    localparam int CTRL_GLOBAL_MASK = 0;

    localparam int HP_CHANNELS = 6;
    localparam int HP_SHORT_FLAGS = 12;

    // Implemented flag bits per status word
    localparam logic [15:0] S4_VALID = 16'h00FF;
    localparam logic [15:0] S5_VALID = 16'h013B;
    localparam logic [15:0] S6_VALID = 16'hFFFF;
    localparam logic [15:0] AOD_VALID = 16'h00C0;

    localparam logic [15:0] MASK_RST = 16'hFFFF;
    localparam logic [15:0] MASK_FIVE_RST = 16'hFEFF;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic CTRL_RST = 1'b0;

    // Source condition levels from the surrounding functions
    typedef struct packed {
        logic [5:0] hpEnableDone;
        logic inputRateConvBCfgError;
        logic inputRateConvCCfgError;
        logic bootComplete;
        logic converterOverflow;
        logic converterFifo;
        logic asyncRateConvCfgError;
        logic loopAClockOk;
        logic loopBClockOk;
        logic sharedMemCollision;
        logic speakerShutdown;
        logic rightSpeakerShort;
        logic leftSpeakerShort;
        logic [11:0] hpShort;
        logic micClamp;
    } sirq_src_t;

    typedef struct packed {
        logic [15:0] four;
        logic [15:0] five;
        logic [15:0] six;
        logic [15:0] always_on_domain;
    } sirq_words_t;

endpackage : sirq_pkg

// file: src/sirq_event_latch.sv
`timescale 1ns/1ps
// Overview of operation
// - Each event flag stays set until the host writes a one to its bit.
// - Six headphone enable-done flags in bits 5..0 of word four set on rising edges.
// - Rate converter B and C config-error flags in bits 7 and 6 of word four set on rising edges.
// - Word five latches boot done (8), overflow (5), FIFO (4) and async config error (3) on rises.
// - Loop A and B clock-OK flags in bits 0 and 1 of word five set on either edge.
// - Bit 15 of word six sets on a rising edge of a shared memory write collision.
// - Speaker shutdown (14) and right/left short (13, 12) set on either edge.
// - Twelve headphone short flags in bits 11..0 of word six set on rising edges.
// - Six mask words; words four to six mirror the three status words bit for bit, words one to three guard no flags.
// - A mask bit of 0 lets its flag reach the output, 1 blocks it.
// - After reset only the boot done mask bit is clear; all other mask bits are set.
// - Bit 0 of the output control word, reset 0, suppresses the output when 1.
// - The always-on word holds a mic clamp falling-edge flag (7) and rising-edge flag (6).
// - The always-on flags have their own mask word, reset to all ones.
module sirq_event_latch #(
    parameter int ADDR_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sirq_pkg::sirq_src_t src,
    output logic secondInterruptOutput
);

    // Loop-placed fields must stay clear of their neighbours
    localparam int HP_DONE_END = sirq_pkg::S4_HP_DONE_LSB + sirq_pkg::HP_CHANNELS;
    localparam int HP_SHORT_END = sirq_pkg::S6_HP_SHORT_LSB + sirq_pkg::HP_SHORT_FLAGS;

    // Settings the decode cannot serve are refused at elaboration
    if (ADDR_W < sirq_pkg::IDX_W + sirq_pkg::BYTE_SHIFT) begin : g_addr_low_chk
        $error("ADDR_W too narrow for the register map");
    end
    if (ADDR_W > 32) begin : g_addr_high_chk
        $error("ADDR_W wider than an APB address");
    end
    if (sirq_pkg::REG_W != $bits(sirq_pkg::MASK_RST)) begin : g_width_chk
        $error("Register words are sixteen bits wide");
    end
    if (HP_DONE_END > sirq_pkg::S4_ISRC_C_ERR) begin : g_done_chk
        $error("Enable-done flags run into the converter flags");
    end
    if (HP_SHORT_END > sirq_pkg::S6_SPK_SHORT_L) begin : g_short_chk
        $error("Short flags run into the speaker flags");
    end
    if (sirq_pkg::MASK_FIVE_RST[sirq_pkg::S5_BOOT_DONE] != 1'b0) begin : g_boot_chk
        $error("Boot complete must leave reset unmasked");
    end

    // Edge helpers shared by all words
    function automatic logic riseOf(input logic now, input logic was);
        riseOf = now & ~was;
    endfunction : riseOf

    function automatic logic fallOf(input logic now, input logic was);
        fallOf = ~now & was;
    endfunction : fallOf

    function automatic logic hitIndex(
        input logic [ADDR_W-1:0] addr,
        input logic [sirq_pkg::IDX_W-1:0] idx
    );
        logic [ADDR_W-1:0] want;
        want = ADDR_W'(idx) << sirq_pkg::BYTE_SHIFT;
        hitIndex = (addr == want);
    endfunction : hitIndex

    // Clears a flag where a one is written, unless a new event lands now
    function automatic logic [15:0] w1cUpdate(
        input logic [15:0] cur,
        input logic [15:0] clr,
        input logic [15:0] ev,
        input logic [15:0] valid
    );
        w1cUpdate = ((cur & ~clr) | ev) & valid;
    endfunction : w1cUpdate

    sirq_pkg::sirq_src_t srcPrev_r;
    sirq_pkg::sirq_words_t event_nxt;
    sirq_pkg::sirq_words_t status_r;
    logic [15:0] maskOne_r;
    logic [15:0] maskTwo_r;
    logic [15:0] maskThree_r;
    logic [15:0] maskFour_r;
    logic [15:0] maskFive_r;
    logic [15:0] maskSix_r;
    logic [15:0] maskAod_r;
    logic globalMask_r;
    logic [15:0] wrData;
    logic accessDone;
    logic wrDone;
    logic rdAccept;
    logic [15:0] clrFour;
    logic [15:0] clrFive;
    logic [15:0] clrSix;
    logic [15:0] clrAod;
    logic mapped;
    logic [15:0] rdWord;
    logic pending_nxt;
    logic pendFour;
    logic pendFive;
    logic pendSix;
    logic pendAod;
    logic outLevel_nxt;

    // Previous source levels for edge detection
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            srcPrev_r <= '0;
        end else begin
            srcPrev_r <= src;
        end
    end

    // Edge events in status word layout
    always_comb begin
        event_nxt = '0;
        for (int i = 0; i < sirq_pkg::HP_CHANNELS; i++) begin
            event_nxt.four[sirq_pkg::S4_HP_DONE_LSB + i] =
                riseOf(src.hpEnableDone[i], srcPrev_r.hpEnableDone[i]);
        end
        event_nxt.four[sirq_pkg::S4_ISRC_B_ERR] =
            riseOf(src.inputRateConvBCfgError, srcPrev_r.inputRateConvBCfgError);
        event_nxt.four[sirq_pkg::S4_ISRC_C_ERR] =
            riseOf(src.inputRateConvCCfgError, srcPrev_r.inputRateConvCCfgError);
        event_nxt.five[sirq_pkg::S5_BOOT_DONE] =
            riseOf(src.bootComplete, srcPrev_r.bootComplete);
        event_nxt.five[sirq_pkg::S5_ADC_OVF] =
            riseOf(src.converterOverflow, srcPrev_r.converterOverflow);
        event_nxt.five[sirq_pkg::S5_ADC_FIFO] =
            riseOf(src.converterFifo, srcPrev_r.converterFifo);
        event_nxt.five[sirq_pkg::S5_ASRC_ERR] =
            riseOf(src.asyncRateConvCfgError, srcPrev_r.asyncRateConvCfgError);
        event_nxt.five[sirq_pkg::S5_LOOP_A_OK] =
            src.loopAClockOk ^ srcPrev_r.loopAClockOk;
        event_nxt.five[sirq_pkg::S5_LOOP_B_OK] =
            src.loopBClockOk ^ srcPrev_r.loopBClockOk;
        event_nxt.six[sirq_pkg::S6_SHARED_COLL] =
            riseOf(src.sharedMemCollision, srcPrev_r.sharedMemCollision);
        event_nxt.six[sirq_pkg::S6_SPK_SHUTDOWN] =
            src.speakerShutdown ^ srcPrev_r.speakerShutdown;
        event_nxt.six[sirq_pkg::S6_SPK_SHORT_R] =
            src.rightSpeakerShort ^ srcPrev_r.rightSpeakerShort;
        event_nxt.six[sirq_pkg::S6_SPK_SHORT_L] =
            src.leftSpeakerShort ^ srcPrev_r.leftSpeakerShort;
        for (int i = 0; i < sirq_pkg::HP_SHORT_FLAGS; i++) begin
            event_nxt.six[sirq_pkg::S6_HP_SHORT_LSB + i] =
                riseOf(src.hpShort[i], srcPrev_r.hpShort[i]);
        end
        event_nxt.always_on_domain[sirq_pkg::AOD_CLAMP_FALL] =
            fallOf(src.micClamp, srcPrev_r.micClamp);
        event_nxt.always_on_domain[sirq_pkg::AOD_CLAMP_RISE] =
            riseOf(src.micClamp, srcPrev_r.micClamp);
    end

    // Bus decode; a write lands only at the completing edge
    assign accessDone = psel & penable & pready;
    assign wrDone = accessDone & pwrite;
    assign rdAccept = psel & penable & ~pready;
    assign wrData = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};

    assign clrFour = (wrDone && hitIndex(paddr, sirq_pkg::IDX_STATUS_FOUR)) ? wrData : '0;
    assign clrFive = (wrDone && hitIndex(paddr, sirq_pkg::IDX_STATUS_FIVE)) ? wrData : '0;
    assign clrSix = (wrDone && hitIndex(paddr, sirq_pkg::IDX_STATUS_SIX)) ? wrData : '0;
    assign clrAod = (wrDone && hitIndex(paddr, sirq_pkg::IDX_AOD_STATUS)) ? wrData : '0;

    // Sticky flags latch regardless of any mask
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= {4{sirq_pkg::STATUS_RST}};
        end else begin
            status_r.four <= w1cUpdate(status_r.four, clrFour, event_nxt.four,
                sirq_pkg::S4_VALID);
            status_r.five <= w1cUpdate(status_r.five, clrFive, event_nxt.five,
                sirq_pkg::S5_VALID);
            status_r.six <= w1cUpdate(status_r.six, clrSix, event_nxt.six,
                sirq_pkg::S6_VALID);
            status_r.always_on_domain <= w1cUpdate(status_r.always_on_domain, clrAod, event_nxt.always_on_domain,
                sirq_pkg::AOD_VALID);
        end
    end

    // Mask words; words one to three keep no flags here but stay writable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            maskOne_r <= sirq_pkg::MASK_RST;
            maskTwo_r <= sirq_pkg::MASK_RST;
            maskThree_r <= sirq_pkg::MASK_RST;
            maskFour_r <= sirq_pkg::MASK_RST;
            maskFive_r <= sirq_pkg::MASK_FIVE_RST;
            maskSix_r <= sirq_pkg::MASK_RST;
        end else if (wrDone) begin
            if (hitIndex(paddr, sirq_pkg::IDX_MASK_ONE)) begin
                maskOne_r <= pwdata[15:0];
            end
            if (hitIndex(paddr, sirq_pkg::IDX_MASK_TWO)) begin
                maskTwo_r <= pwdata[15:0];
            end
            if (hitIndex(paddr, sirq_pkg::IDX_MASK_THREE)) begin
                maskThree_r <= pwdata[15:0];
            end
            if (hitIndex(paddr, sirq_pkg::IDX_MASK_FOUR)) begin
                maskFour_r <= pwdata[15:0];
            end
            if (hitIndex(paddr, sirq_pkg::IDX_MASK_FIVE)) begin
                maskFive_r <= pwdata[15:0];
            end
            if (hitIndex(paddr, sirq_pkg::IDX_MASK_SIX)) begin
                maskSix_r <= pwdata[15:0];
            end
        end
    end

    // Always-on mask word; kept apart from the main words, reset by the same sys_rst
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            maskAod_r <= sirq_pkg::MASK_RST;
        end else if (wrDone && hitIndex(paddr, sirq_pkg::IDX_AOD_MASK)) begin
            maskAod_r <= pwdata[15:0];
        end
    end

    // Global output mask
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            globalMask_r <= sirq_pkg::CTRL_RST;
        end else if (wrDone && hitIndex(paddr, sirq_pkg::IDX_OUT_CTRL)) begin
            globalMask_r <= pwdata[sirq_pkg::CTRL_GLOBAL_MASK];
        end
    end

    // Pending term per status word
    always_comb begin
        pendFour = |(status_r.four & ~maskFour_r);
        pendFive = |(status_r.five & ~maskFive_r);
        pendSix = |(status_r.six & ~maskSix_r);
        pendAod = |(status_r.always_on_domain & ~maskAod_r);
        outLevel_nxt = ~globalMask_r & (pendFour | pendFive | pendSix | pendAod);
    end

    // Registered so the pin never glitches on mask writes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            secondInterruptOutput <= 1'b0;
        end else begin
            secondInterruptOutput <= outLevel_nxt;
        end
    end

    // Read data and map check
    always_comb begin
        mapped = 1'b1;
        rdWord = '0;
        case (paddr[ADDR_W-1:sirq_pkg::BYTE_SHIFT])
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_STATUS_FOUR): begin
                rdWord = status_r.four;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_STATUS_FIVE): begin
                rdWord = status_r.five;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_STATUS_SIX): begin
                rdWord = status_r.six;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_MASK_ONE): begin
                rdWord = maskOne_r;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_MASK_TWO): begin
                rdWord = maskTwo_r;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_MASK_THREE): begin
                rdWord = maskThree_r;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_MASK_FOUR): begin
                rdWord = maskFour_r;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_MASK_FIVE): begin
                rdWord = maskFive_r;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_MASK_SIX): begin
                rdWord = maskSix_r;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_OUT_CTRL): begin
                rdWord = {15'h0000, globalMask_r};
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_AOD_STATUS): begin
                rdWord = status_r.always_on_domain;
            end
            (ADDR_W-sirq_pkg::BYTE_SHIFT)'(sirq_pkg::IDX_AOD_MASK): begin
                rdWord = maskAod_r;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        if (paddr[sirq_pkg::BYTE_SHIFT-1:0] != '0) begin
            mapped = 1'b0;
            rdWord = '0;
        end
    end

    // One wait state: ready rises on the second access cycle
    assign pending_nxt = rdAccept;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= pending_nxt;
        end
    end

    // Read data sampled with status as of the ready edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= '0;
        end else if (rdAccept) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rdWord};
        end else begin
            prdata <= '0;
        end
    end

    // Unmapped or unaligned answers with an error, write or read alike
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= rdAccept & ~mapped;
        end
    end

endmodule : sirq_event_latch

// file: dv/sirq_event_latch_sva.sv
`timescale 1ns/1ps
module sirq_event_latch_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire sirq_pkg::sirq_src_t src,
    input wire logic secondInterruptOutput
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    ready_timing_a: assert property ($rose(psel && penable) |=> pready)
        else $error("no answer one cycle into access");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("answer without access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    idle_data_a: assert property (!pready |-> prdata == 32'h00000000)
        else $error("read data outside answer");
    upper_zero_a: assert property (prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    err_pulse_a: assert property (pslverr |-> pready)
        else $error("error without answer");
    // A rise needs a source change or a register write two edges back
    irq_rise_a: assert property ($rose(secondInterruptOutput) |->
        $past(src, 2) != $past(src, 3) || $past(pready && pwrite, 2)
        || $past(sys_rst, 2) || $past(sys_rst, 3))
        else $error("interrupt rose without cause");
    // Sticky flags: only a host write can drop the output
    irq_fall_a: assert property ($fell(secondInterruptOutput) |-> $past(pready && pwrite, 2))
        else $error("interrupt fell without write");

    cover property ($rose(secondInterruptOutput));
    cover property (pslverr);
    cover property (pready && pwrite);
endmodule : sirq_event_latch_chk

bind sirq_event_latch sirq_event_latch_chk u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src(src), .secondInterruptOutput(secondInterruptOutput));

// file: dv/sirq_host_model.sv
`timescale 1ns/1ps
module sirq_host_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic secondInterruptOutput,
    output logic [7:0] riseCount
);
    logic irqSeen_r;

    // Level output, so only a rise is a new service request
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqSeen_r <= 1'b0;
            riseCount <= 8'h00;
        end else begin
            irqSeen_r <= secondInterruptOutput;
            if (secondInterruptOutput && !irqSeen_r) begin
                riseCount <= riseCount + 8'h01;
            end
        end
    end
endmodule : sirq_host_model

// file: dv/secondary_irq_event_latch_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module secondary_irq_event_latch_tb;
    logic clk;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic collide = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rv;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] riseCount;
    sirq_pkg::sirq_src_t src = '0;
    sirq_pkg::sirq_src_t prevSrc;
    sirq_pkg::sirq_words_t expW;
    sirq_pkg::sirq_words_t mk;
    logic [17:0] expQ[$];
    logic [17:0] e;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [11:0] idxTab[12] = '{sirq_pkg::IDX_STATUS_FOUR, sirq_pkg::IDX_STATUS_FIVE,
        sirq_pkg::IDX_STATUS_SIX, sirq_pkg::IDX_MASK_ONE, sirq_pkg::IDX_MASK_TWO,
        sirq_pkg::IDX_MASK_THREE, sirq_pkg::IDX_MASK_FOUR, sirq_pkg::IDX_MASK_FIVE,
        sirq_pkg::IDX_MASK_SIX, sirq_pkg::IDX_OUT_CTRL, sirq_pkg::IDX_AOD_STATUS,
        sirq_pkg::IDX_AOD_MASK};
    logic [15:0] rstTab[12] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFEFF, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF};

    sirq_event_latch #(.ADDR_W(16)) dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
        .secondInterruptOutput(irq));
    sirq_host_model host (.clk(clk), .sys_rst(sys_rst), .secondInterruptOutput(irq),
        .riseCount(riseCount));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            end_sim();
        end
    end

    // Each answer is judged against the oldest note, output level included
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            e = expQ.pop_front();
            `CHK({irq, pslverr}, e[17:16])
            if (!pwrite) `CHK(prdata, {16'h0000, e[15:0]})
        end
    end

    task automatic xfer(input logic w, input logic [11:0] idx, input logic [15:0] d,
        input logic [17:0] x);
        expQ.push_back(x);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clk);
        penable <= 1'b1;
        if (collide) begin
            // Rise must land on the completing edge to meet the clear
            wait (pready === 1'b1);
            src.sharedMemCollision <= 1'b1;
        end
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [11:0] idx, input logic [15:0] d, input logic er,
        input logic i);
        xfer(1'b0, idx, 16'h0000, {i, er, d});
    endtask : rd

    task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic i);
        xfer(1'b1, idx, d, {i, 1'b0, 16'h0000});
    endtask : wr

    function automatic sirq_pkg::sirq_words_t edges(input sirq_pkg::sirq_src_t o,
        input sirq_pkg::sirq_src_t n);
        sirq_pkg::sirq_words_t w;
        w = '0;
        w.four[5:0] = n.hpEnableDone & ~o.hpEnableDone;
        w.four[7] = n.inputRateConvBCfgError & ~o.inputRateConvBCfgError;
        w.four[6] = n.inputRateConvCCfgError & ~o.inputRateConvCCfgError;
        w.five[8] = n.bootComplete & ~o.bootComplete;
        w.five[5] = n.converterOverflow & ~o.converterOverflow;
        w.five[4] = n.converterFifo & ~o.converterFifo;
        w.five[3] = n.asyncRateConvCfgError & ~o.asyncRateConvCfgError;
        w.five[1] = n.loopBClockOk ^ o.loopBClockOk;
        w.five[0] = n.loopAClockOk ^ o.loopAClockOk;
        w.six[15] = n.sharedMemCollision & ~o.sharedMemCollision;
        w.six[14] = n.speakerShutdown ^ o.speakerShutdown;
        w.six[13] = n.rightSpeakerShort ^ o.rightSpeakerShort;
        w.six[12] = n.leftSpeakerShort ^ o.leftSpeakerShort;
        w.six[11:0] = n.hpShort & ~o.hpShort;
        w.always_on_domain[6] = n.micClamp & ~o.micClamp;
        w.always_on_domain[7] = ~n.micClamp & o.micClamp;
        return w;
    endfunction : edges

    function automatic logic irqOf(input sirq_pkg::sirq_words_t m);
        return |((expW.four & ~m.four) | (expW.five & ~m.five) | (expW.six & ~m.six)
            | (expW.always_on_domain & ~m.always_on_domain));
    endfunction : irqOf

    initial begin
        void'($urandom(32'h7674));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 12; k++) rd(idxTab[k], rstTab[k], 1'b0, 1'b0);
        rd(12'hD16, 16'h0000, 1'b1, 1'b0);
        xfer(1'b1, 12'hD17, 16'hFFFF, {1'b0, 1'b1, 16'h0000});
        $display("test reset_map done");
        @(posedge clk);
        src.bootComplete <= 1'b1;
        rd(sirq_pkg::IDX_STATUS_FIVE, 16'h0100, 1'b0, 1'b1);
        wr(sirq_pkg::IDX_STATUS_FIVE, 16'h0000, 1'b1);
        wr(sirq_pkg::IDX_OUT_CTRL, 16'h0001, 1'b1);
        rd(sirq_pkg::IDX_STATUS_FIVE, 16'h0100, 1'b0, 1'b0);
        wr(sirq_pkg::IDX_OUT_CTRL, 16'h0000, 1'b0);
        wr(sirq_pkg::IDX_STATUS_FIVE, 16'h0100, 1'b1);
        rd(sirq_pkg::IDX_STATUS_FIVE, 16'h0000, 1'b0, 1'b0);
        `CHK(riseCount, 8'h02)
        $display("test boot_event done");
        wr(sirq_pkg::IDX_MASK_FIVE, 16'hFFFF, 1'b0);
        expW = '0;
        prevSrc = src;
        repeat (200) begin
            @(posedge clk);
            rv = $urandom();
            src <= rv[$bits(src)-1:0];
            expW = expW | edges(prevSrc, rv[$bits(src)-1:0]);
            prevSrc = rv[$bits(src)-1:0];
        end
        rd(sirq_pkg::IDX_STATUS_FOUR, expW.four, 1'b0, 1'b0);
        rd(sirq_pkg::IDX_STATUS_FIVE, expW.five, 1'b0, 1'b0);
        rd(sirq_pkg::IDX_STATUS_SIX, expW.six, 1'b0, 1'b0);
        rd(sirq_pkg::IDX_AOD_STATUS, expW.always_on_domain, 1'b0, 1'b0);
        $display("test random_edges done");
        mk = '1;
        rv = $urandom();
        wr(sirq_pkg::IDX_MASK_FOUR, rv[15:0], irqOf(mk));
        mk.four = rv[15:0];
        wr(sirq_pkg::IDX_MASK_FIVE, rv[31:16], irqOf(mk));
        mk.five = rv[31:16];
        rv = $urandom();
        wr(sirq_pkg::IDX_MASK_SIX, rv[15:0], irqOf(mk));
        mk.six = rv[15:0];
        wr(sirq_pkg::IDX_AOD_MASK, rv[31:16], irqOf(mk));
        mk.always_on_domain = rv[31:16];
        rd(sirq_pkg::IDX_MASK_SIX, mk.six, 1'b0, irqOf(mk));
        wr(sirq_pkg::IDX_MASK_SIX, 16'h7FFF, irqOf(mk));
        mk.six = 16'h7FFF;
        src.sharedMemCollision <= 1'b0;
        wr(sirq_pkg::IDX_STATUS_SIX, 16'hFFFF, irqOf(mk));
        expW.six = 16'h0000;
        collide = 1'b1;
        wr(sirq_pkg::IDX_STATUS_SIX, 16'hFFFF, irqOf(mk));
        collide = 1'b0;
        expW.six = 16'h8000;
        rd(sirq_pkg::IDX_STATUS_SIX, 16'h8000, 1'b0, irqOf(mk));
        $display("test mask_and_collide done");
        @(posedge clk);
        end_sim();
    end
endmodule : secondary_irq_event_latch_tb
